/* File: hdl/soec_device.sv */
// expander stage: 8-bit shift stage, 8-bit storage, three-state outputs
// assumes the host keeps shiftClock low and stable around latchClock edges
//
// Contract
// - eight-bit shift stage feeding eight-bit storage
// - storage drives eight three-state parallel outputs
// - separate shift and latch clock inputs
// - clear resets shift stage regardless of clock
// - outputs off floats pins, chain out drives
// - last stage drives chain output
// - outputs hold old value while shifting
// - host shifts bits then pulses latch clock
// - eight shifts per chained device before latch
// - host reloads whole chain within 33.3 ms
// - each output bit drives one segment
// - host uses only four control lines
// - clocks low, shift each bit, then latch
// - storage holds until next latch pulse
// - host may modulate output enable for brightness
`timescale 1ns/1ps
module soec_device (
  soec_link_if.device                  lnk,       // link wires from the host
  output logic [soec_pkg::STAGE_BITS-1:0] parOut,    // parallel output values
  output logic [soec_pkg::STAGE_BITS-1:0] parOutEn,  // high while a pin is driven
  output logic [soec_pkg::STAGE_BITS-1:0] stageView  // shift stage, for observation
);
  import soec_pkg::*;

  logic [STAGE_BITS-1:0] shift_ff;  // shift stage, shiftClock domain
  logic [STAGE_BITS-1:0] store_ff;  // storage, latchClock domain

  // shift stage: bit enters stage 0, each stage moves toward chain out;
  // clear is asynchronous so it wins over any edge in progress
  always_ff @(posedge lnk.shiftClock or negedge lnk.shiftClearN) begin
    if (!lnk.shiftClearN) begin
      shift_ff <= STAGE_CLEAR;
    end else begin
      shift_ff <= {shift_ff[STAGE_BITS-2:0], lnk.bitIn};
    end
  end

  // storage copies all stages on its own clock; no reset, so it holds
  // until the next latch edge. the stage is quiet at that edge because
  // the host never raises both clocks together, which makes this
  // a quasi-static transfer rather than a free-running crossing
  always_ff @(posedge lnk.latchClock) begin
    store_ff <= shift_ff;
  end

  // last stage feeds the next device and is never floated
  assign lnk.chainOut = shift_ff[STAGE_BITS-1];

  // per-pin three-state cell; shifting leaves the storage untouched
  genvar gi;
  generate
    for (gi = 0; gi < STAGE_BITS; gi++) begin : g_pin
      assign parOut[gi]   = store_ff[gi];
      assign parOutEn[gi] = lnk.outputsOffN == 1'b0;
    end
  endgenerate

  // observation tap of the shift stage for the user side
  assign stageView = shift_ff;

endmodule

/* File: hdl/soec_host.sv */
// host controller end: loads the expander chain over the link wires
// assumes one clk domain; the link clocks are made here by counting
`timescale 1ns/1ps
module soec_host #(
  parameter int REFRESH_CYC = soec_pkg::FRAME_CYC  // reload period in clk cycles
) (
  input  wire logic                            clk,        // host clock, 10 MHz
  input  wire logic                            srst,       // sync reset, active high
  input  wire logic                            loadReq,    // start a load of loadData
  input  wire logic [soec_pkg::CHAIN_BITS-1:0] loadData,   // chain image, msb shifted first
  output logic                                 loadReady,  // load or clear may be taken
  output logic                                 loadDone,   // one-cycle end of a sequence
  input  wire logic                            clearReq,   // clear stage and latch zeros
  input  wire logic                            refreshEn,  // periodic reload of last image
  input  wire logic [soec_pkg::PWM_W-1:0]      dimDuty,    // brightness duty, 0 is dark
  input  wire logic                            displayOn,  // allow outputs to drive
  output logic [soec_pkg::CHAIN_BITS-1:0]      echoData,   // chain content pushed out last load
  soec_link_if.host                            lnk         // link wires to the chain
);
  import soec_pkg::*;

  localparam int RT_W = $clog2(REFRESH_CYC + 1);
  localparam logic [RT_W-1:0] RT_LAST = RT_W'(REFRESH_CYC - 1);
  localparam logic [RT_W-1:0] RT_ONE  = RT_W'(1);

  soec_hstate_t          state_ff;
  soec_hstate_t          nxt_state;
  logic [TIMER_W-1:0]    timer_ff;
  logic [BIT_IDX_W-1:0]  bitIdx_ff;
  logic [CHAIN_BITS-1:0] hold_ff;
  logic [CHAIN_BITS-1:0] send_ff;
  logic [CHAIN_BITS-1:0] echo_ff;
  logic [CHAIN_BITS-1:0] echoOut_ff;
  logic [RT_W-1:0]       refresh_ff;
  logic                  refreshDue_ff;
  logic                  chainMeta_ff;
  logic                  chainSync_ff;
  logic [PWM_W-1:0]      pwm_ff;
  logic                  bitIn_ff;
  logic                  shiftClk_ff;
  logic                  latchClk_ff;
  logic                  clearN_ff;
  logic                  offN_ff;
  logic                  done_ff;
  logic                  phaseEnd;
  logic                  seqStart;

  assign phaseEnd = timer_ff == TIMER_LAST;
  assign seqStart = (state_ff == HST_IDLE) && (nxt_state != HST_IDLE);

  // sequencer: clocks low, per bit set data then raise shift, then latch
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HST_IDLE: begin
        if (clearReq) begin
          nxt_state = HST_CLEAR;
        end else if (loadReq || refreshDue_ff) begin
          nxt_state = HST_SETUP;
        end
      end
      HST_CLEAR: begin
        if (phaseEnd) nxt_state = HST_LATCH;
      end
      HST_SETUP: begin
        if (phaseEnd) nxt_state = HST_RISE;
      end
      HST_RISE: begin
        if (phaseEnd) begin
          // whole chain shifted before any latch
          nxt_state = (bitIdx_ff == BIT_IDX_LAST) ? HST_LATCH : HST_SETUP;
        end
      end
      HST_LATCH: begin
        if (phaseEnd) nxt_state = HST_DONE;
      end
      HST_DONE: begin
        if (phaseEnd) nxt_state = HST_IDLE;
      end
      default: nxt_state = HST_IDLE;
    endcase
  end

  // state and phase timer; reset lands in clear so outputs become zero
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= HST_CLEAR;
      timer_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || state_ff == HST_IDLE) begin
        timer_ff <= '0;
      end else begin
        timer_ff <= timer_ff + TIMER_ONE;
      end
    end
  end

  // image to send, kept image for refresh, bit counter
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_ff   <= CHAIN_CLEAR;
      send_ff   <= CHAIN_CLEAR;
      bitIdx_ff <= '0;
    end else if (state_ff == HST_IDLE) begin
      bitIdx_ff <= '0;
      if (clearReq) begin
        hold_ff <= CHAIN_CLEAR;
      end else if (loadReq) begin
        hold_ff <= loadData;
        send_ff <= loadData;
      end else if (refreshDue_ff) begin
        send_ff <= hold_ff;
      end
    end else if (state_ff == HST_RISE && phaseEnd) begin
      send_ff   <= {send_ff[CHAIN_BITS-2:0], 1'b0};
      bitIdx_ff <= bitIdx_ff + BIT_IDX_ONE;
    end
  end

  // link pins from flops; only shift, latch, clear, off and data are used
  always_ff @(posedge clk) begin
    if (srst) begin
      bitIn_ff    <= 1'b0;
      shiftClk_ff <= 1'b0;
      latchClk_ff <= 1'b0;
      clearN_ff   <= 1'b0;
    end else begin
      if (state_ff == HST_SETUP) begin
        bitIn_ff <= send_ff[CHAIN_BITS-1];
      end
      shiftClk_ff <= nxt_state == HST_RISE;
      latchClk_ff <= nxt_state == HST_LATCH;
      clearN_ff   <= nxt_state != HST_CLEAR;
    end
  end

  // reload timer keeps the whole chain fresh within one frame
  always_ff @(posedge clk) begin
    if (srst) begin
      refresh_ff    <= '0;
      refreshDue_ff <= 1'b0;
    end else if (seqStart) begin
      refresh_ff    <= '0;
      refreshDue_ff <= 1'b0;
    end else if (refreshEn && !refreshDue_ff) begin
      if (refresh_ff == RT_LAST) begin
        refreshDue_ff <= 1'b1;
      end else begin
        refresh_ff <= refresh_ff + RT_ONE;
      end
    end
  end

  // chain return comes from another clock, so two flops first
  always_ff @(posedge clk) begin
    if (srst) begin
      chainMeta_ff <= 1'b0;
      chainSync_ff <= 1'b0;
    end else begin
      chainMeta_ff <= lnk.chainOut;
      chainSync_ff <= chainMeta_ff;
    end
  end

  // echo: sampled just before each shift edge, so it is the old content
  always_ff @(posedge clk) begin
    if (srst) begin
      echo_ff    <= CHAIN_CLEAR;
      echoOut_ff <= CHAIN_CLEAR;
    end else begin
      if (state_ff == HST_SETUP && phaseEnd) begin
        echo_ff <= {echo_ff[CHAIN_BITS-2:0], chainSync_ff};
      end
      if (state_ff == HST_RISE && phaseEnd && bitIdx_ff == BIT_IDX_LAST) begin
        echoOut_ff <= echo_ff;
      end
    end
  end

  // brightness: free-running duty counter gates the output enable
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_ff  <= '0;
      offN_ff <= 1'b1;
    end else begin
      pwm_ff  <= pwm_ff + PWM_ONE;
      offN_ff <= !(displayOn && (pwm_ff < dimDuty));
    end
  end

  // end-of-sequence pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == HST_DONE) && phaseEnd;
    end
  end

  // clear has priority, so a load is not taken in the same cycle
  assign loadReady       = (state_ff == HST_IDLE) && !clearReq;
  assign loadDone        = done_ff;
  assign echoData        = echoOut_ff;
  assign lnk.bitIn       = bitIn_ff;
  assign lnk.shiftClock  = shiftClk_ff;
  assign lnk.latchClock  = latchClk_ff;
  assign lnk.shiftClearN = clearN_ff;
  assign lnk.outputsOffN = offN_ff;

endmodule

/* File: shared/soec_link_if.sv */
// link wires between the host controller and the expander stage
// no clocking block; the host makes every clock on these wires
`timescale 1ns/1ps
interface soec_link_if;
  logic bitIn;        // serial data toward the first stage
  logic shiftClock;   // rising edge shifts the stage
  logic latchClock;   // rising edge copies stage to storage
  logic shiftClearN;  // async clear of the shift stage
  logic outputsOffN;  // high floats the parallel outputs
  logic chainOut;     // last stage, feeds the next device

  modport device (
    input  bitIn,
    input  shiftClock,
    input  latchClock,
    input  shiftClearN,
    input  outputsOffN,
    output chainOut
  );

  modport host (
    output bitIn,
    output shiftClock,
    output latchClock,
    output shiftClearN,
    output outputsOffN,
    input  chainOut
  );
endinterface

/* File: shared/soec_pkg.sv */
// shared constants and types for the serial output expander chain
// assumes a 100 ns host clock; the device end runs only on link clocks
package soec_pkg;

  // host clock period and stage geometry
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAGE_BITS    = 8;
  localparam int CHAIN_DEV     = 1;
  localparam int CHAIN_BITS    = STAGE_BITS * CHAIN_DEV;

  // each half of a shift or latch pulse, least time so rounded up
  localparam int EDGE_HOLD_NS  = 500;
  localparam int EDGE_HOLD_RAW = (EDGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EDGE_HOLD_CYC = (EDGE_HOLD_RAW < 1) ? 1 : EDGE_HOLD_RAW;
  localparam int TIMER_W       = $clog2(EDGE_HOLD_CYC + 1);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(EDGE_HOLD_CYC - 1);

  // bit counter over the whole chain
  localparam int BIT_IDX_W = $clog2(CHAIN_BITS + 1);
  localparam logic [BIT_IDX_W-1:0] BIT_IDX_LAST = BIT_IDX_W'(CHAIN_BITS - 1);
  localparam logic [BIT_IDX_W-1:0] BIT_IDX_ONE  = BIT_IDX_W'(1);

  // whole-chain refresh bound, longest time so rounded down
  localparam int FRAME_US      = 33300;
  localparam int FRAME_CYC_RAW = FRAME_US * 1000 / CLK_PERIOD_NS;
  localparam int FRAME_CYC     = (FRAME_CYC_RAW < 1) ? 1 : FRAME_CYC_RAW;

  // brightness modulation and reset values
  localparam int PWM_W = 8;
  localparam logic [PWM_W-1:0]      PWM_ONE     = PWM_W'(1);
  localparam logic [TIMER_W-1:0]    TIMER_ONE   = TIMER_W'(1);
  localparam logic [CHAIN_BITS-1:0] CHAIN_CLEAR = '0;
  localparam logic [STAGE_BITS-1:0] STAGE_CLEAR = '0;

  // host sequencer states
  typedef enum {
    HST_IDLE,
    HST_CLEAR,
    HST_SETUP,
    HST_RISE,
    HST_LATCH,
    HST_DONE
  } soec_hstate_t;

endpackage

/* File: tb/serial_output_expander_chain_test.sv */
// host and expander joined by the link interface, ordinary loads from a table
// assumes one expander in the chain and a shortened refresh period
`timescale 1ns/1ps
module serial_output_expander_chain_test;
  import soec_pkg::*;
  typedef struct packed {logic [7:0] data; logic [7:0] par; logic [7:0] echo;} soec_row_t;
  logic                  clk, srst, loadReq, loadReady, loadDone, clearReq, refreshEn, displayOn;
  logic [PWM_W-1:0]      dimDuty;
  logic [CHAIN_BITS-1:0] loadData, echoData;
  logic [STAGE_BITS-1:0] parOut, parOutEn, stageView;
  int                    errors, comparisons;
  // each load leaves the previous image on the echo
  soec_row_t rows [5] = '{'{8'ha5, 8'ha5, 8'h00}, '{8'h3c, 8'h3c, 8'ha5},
    '{8'hff, 8'hff, 8'h3c}, '{8'h00, 8'h00, 8'hff}, '{8'h81, 8'h81, 8'h00}};

  soec_link_if soec_link_if_inst ();
  // short refresh keeps the periodic reload inside the run
  soec_host #(.REFRESH_CYC(300)) soec_host_inst (.clk(clk), .srst(srst), .loadReq(loadReq),
    .loadData(loadData), .loadReady(loadReady), .loadDone(loadDone), .clearReq(clearReq),
    .refreshEn(refreshEn), .dimDuty(dimDuty), .displayOn(displayOn), .echoData(echoData),
    .lnk(soec_link_if_inst));
  soec_device soec_device_inst (.lnk(soec_link_if_inst), .parOut(parOut),
    .parOutEn(parOutEn), .stageView(stageView));
  soec_link_assertions soec_link_assertions_inst (.clk(clk), .srst(srst),
    .bitIn(soec_link_if_inst.bitIn), .shiftClock(soec_link_if_inst.shiftClock),
    .latchClock(soec_link_if_inst.latchClock), .shiftClearN(soec_link_if_inst.shiftClearN),
    .outputsOffN(soec_link_if_inst.outputsOffN), .chainOut(soec_link_if_inst.chainOut));

  // 10 MHz host clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait for the end-of-sequence pulse
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (loadDone !== 1'b1 && n < 1000);
    check("loadDone", {7'h0, loadDone}, 8'h01);
  endtask

  // request held one edge once ready; clear wins when both are set
  task automatic take(input logic [7:0] d, input logic ld, input logic clr);
    int n;
    n = 0;
    while (loadReady !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("loadReady", {7'h0, loadReady}, 8'h01);
    loadData = d;
    loadReq = ld;
    clearReq = clr;
    tick(1);
    loadReq = 1'b0;
    clearReq = 1'b0;
  endtask

  initial begin
    int onCnt;
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    loadReq = 1'b0;
    clearReq = 1'b0;
    refreshEn = 1'b0;
    displayOn = 1'b1;
    dimDuty = 8'hff;
    loadData = 8'h00;
    tick(4);
    srst = 1'b0;
    // reset runs a clear and a latch of zeros
    wait_done();
    check("parOut after reset", parOut, 8'h00);
    check("stage after reset", stageView, 8'h00);
    foreach (rows[i]) begin
      take(rows[i].data, 1'b1, 1'b0);
      wait_done();
      check("parOut", parOut, rows[i].par);
      check("stage", stageView, rows[i].data);
      check("echo", echoData, rows[i].echo);
      check("chainOut", {7'h0, soec_link_if_inst.chainOut}, {7'h0, rows[i].data[7]});
      check("enables", parOutEn, {8{~soec_link_if_inst.outputsOffN}});
    end
    // outputs hold the old image while the new one shifts in
    take(8'h5a, 1'b1, 1'b0);
    tick(40);
    check("parOut mid load", parOut, 8'h81);
    wait_done();
    check("parOut new", parOut, 8'h5a);
    // clear beats a load in the same cycle
    take(8'hff, 1'b1, 1'b1);
    wait_done();
    check("parOut clear", parOut, 8'h00);
    check("stage clear", stageView, 8'h00);
    take(8'hc3, 1'b1, 1'b0);
    wait_done();
    // display off floats the pins but the chain still drives
    displayOn = 1'b0;
    tick(3);
    check("enables off", parOutEn, 8'h00);
    check("chainOut off", {7'h0, soec_link_if_inst.chainOut}, 8'h01);
    displayOn = 1'b1;
    dimDuty = 8'h00;
    for (int k = 0; k < 8; k++) begin
      tick(37);
      check("enables dark", parOutEn, 8'h00);
    end
    dimDuty = 8'h80;
    // half duty drives the pins for exactly half of one counter period
    onCnt = 0;
    for (int k = 0; k < 256; k++) begin
      tick(1);
      if (parOutEn === 8'hff) onCnt++;
    end
    check("duty on count", 8'(onCnt), 8'h80);
    // periodic reload repeats the kept image
    refreshEn = 1'b1;
    wait_done();
    refreshEn = 1'b0;
    check("parOut refresh", parOut, 8'hc3);
    check("echo refresh", echoData, 8'hc3);
    // reset in mid-load aborts the load and latches zeros again
    take(8'h99, 1'b1, 1'b0);
    tick(30);
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    wait_done();
    check("parOut after mid reset", parOut, 8'h00);
    check("stage after mid reset", stageView, 8'h00);
    results();
  end

  // cuts a hang short; tests take about 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule

/* File: tb/soec_link_assertions.sv */
// checks on the link wires between host and expander, sampled on the host clock
// assumes the host makes every link clock from clk and parks them during reset
`timescale 1ns/1ps
module soec_link_assertions (
  input wire logic clk,          // host clock
  input wire logic srst,         // sync reset, active high
  input wire logic bitIn,        // serial data
  input wire logic shiftClock,   // shift edge
  input wire logic latchClock,   // latch edge
  input wire logic shiftClearN,  // stage clear, active low
  input wire logic outputsOffN,  // high floats the outputs
  input wire logic chainOut      // last stage
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic       shiftPrev_ff;
  logic       latchPrev_ff;
  logic [3:0] shiftCnt_ff;

  // edge history of the link clocks
  always_ff @(posedge clk) begin
    shiftPrev_ff <= shiftClock;
    latchPrev_ff <= latchClock;
  end

  // shifts since last latch; a clear latches with none
  always_ff @(posedge clk) begin
    if (srst || (latchClock && !latchPrev_ff)) shiftCnt_ff <= 4'h0;
    else if (shiftClock && !shiftPrev_ff) shiftCnt_ff <= shiftCnt_ff + 4'h1;
  end

  a_clocks_apart: assert property (!(shiftClock && latchClock))
    else $error("shift and latch clocks high together");
  a_shift_high_five: assert property ($rose(shiftClock) |-> shiftClock[*5] ##1 !shiftClock)
    else $error("shift pulse width wrong");
  a_shift_low_five: assert property ($fell(shiftClock) |-> !shiftClock[*5])
    else $error("shift low phase too short");
  a_latch_high_five: assert property ($rose(latchClock) |-> latchClock[*5] ##1 !latchClock)
    else $error("latch pulse width wrong");
  a_bit_setup_held: assert property ($rose(shiftClock) |-> bitIn == $past(bitIn, 4))
    else $error("serial bit not set up before shift");
  a_bit_stable_high: assert property (shiftClock |-> $stable(bitIn))
    else $error("serial bit moved during shift pulse");
  a_clear_zeros_chain: assert property (!shiftClearN |-> !chainOut)
    else $error("chain output not cleared");
  a_chain_shift_only: assert property ($changed(chainOut) |-> $rose(shiftClock) || !shiftClearN)
    else $error("chain output changed without a shift");
  a_eight_per_load: assert property ($rose(latchClock) |-> shiftCnt_ff inside {4'h0, 4'h8})
    else $error("latch after wrong number of shifts");

  // main scenarios reached
  c_full_load: cover property ($rose(latchClock) && shiftCnt_ff == 4'h8);
  c_outputs_on: cover property ($fell(outputsOffN));
  c_stage_clear: cover property ($fell(shiftClearN));
endmodule
